// ==== common/rspf_pkg.sv ====
// Constants shared by the remote serial port framing block
`default_nettype none
package rspf_pkg;
  localparam int unsigned RSPF_CLK_HZ = 100_000_000;
  localparam int unsigned RSPF_NBAUD = 9;
  localparam int unsigned RSPF_BAUD_TAB [RSPF_NBAUD] = '{
    1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200, 230400};
  localparam int RSPF_DIV_W = 17;
  localparam int RSPF_AW = 8;
  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_TXDATA = 8'h08;
  localparam logic [7:0] OFF_RXDATA = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_EN = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h18;
  ////////////////////////////////////////////////////////////////////////////
  // Control word fields
  localparam int CFG_BAUD_LSB = 0;
  localparam int CFG_FRAME_LSB = 4;
  localparam int CFG_STOP2_BIT = 6;
  localparam int CFG_FLOW_LSB = 7;
  localparam int CFG_EOL_LSB = 9;
  localparam int CFG_PORT_LSB = 11;
  localparam int CFG_W = 13;
  localparam logic [3:0] BAUD_IDX_MAX = 4'h8;
  localparam logic [1:0] NO_PARITY_EIGHT_BIT_FRAME = 2'h0;
  localparam logic [1:0] ODD_PARITY_SEVEN_BIT_FRAME = 2'h1;
  localparam logic [1:0] EVEN_PARITY_SEVEN_BIT_FRAME = 2'h2;
  localparam logic [1:0] FLOW_NONE = 2'h0;
  localparam logic [1:0] FLOW_SW = 2'h1;
  localparam logic [1:0] FLOW_HW = 2'h2;
  localparam logic [1:0] EOL_CR = 2'h0;
  localparam logic [1:0] EOL_LF = 2'h1;
  localparam logic [1:0] EOL_CRLF = 2'h2;
  localparam logic [1:0] SERIAL_PORT_CHOICE = 2'h0;
  localparam logic [1:0] PORT_INSTR_BUS = 2'h1;
  localparam logic [1:0] PORT_LAN = 2'h2;
  localparam logic [1:0] CODE_BAD = 2'h3;
  // 9600 baud, no parity 8 bits, 1 stop, no flow, CR LF, serial port
  localparam logic [CFG_W-1:0] CFG_RESET = 13'h0403;
  ////////////////////////////////////////////////////////////////////////////
  // Characters
  localparam logic [7:0] CHR_XON = 8'h11;
  localparam logic [7:0] CHR_XOFF = 8'h13;
  localparam logic [7:0] CHR_CR = 8'h0d;
  localparam logic [7:0] CHR_LF = 8'h0a;
  localparam int TX_EOL_BIT = 8;
  localparam int RX_PERR_BIT = 8;
  localparam int RX_FERR_BIT = 9;
  ////////////////////////////////////////////////////////////////////////////
  // Status and interrupt bits
  localparam int ST_RX_FULL = 0;
  localparam int ST_HOLD_FULL = 1;
  localparam int ST_TX_BUSY = 2;
  localparam int ST_PAUSED = 3;
  localparam int ST_CTS = 4;
  localparam int ST_NV_LOADED = 5;
  localparam int IRQ_RX = 0;
  localparam int IRQ_PERR = 1;
  localparam int IRQ_OVR = 2;
  localparam int IRQ_EOL = 3;
  localparam int IRQ_TXE = 4;
  localparam int IRQ_W = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : rspf_pkg
`default_nettype wire

// ==== hdl/rspf_rx.sv ====
// Serial receiver for one character frame
`default_nettype none
module rspf_rx
  import rspf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic rxd,
  input wire logic [RSPF_DIV_W-1:0] div,
  input wire logic seven,
  input wire logic par_odd,
  output logic done_q,
  output logic [7:0] data_q,
  output logic perr_q,
  output logic ferr_q
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rspf_rx_st_t;
  rspf_rx_st_t st_q, st_d;
  logic [RSPF_DIV_W-1:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d, data_d;
  logic [2:0] bit_q, bit_d;
  logic prev_q, done_d, perr_d, ferr_d, exp_par, tick;

  always_comb begin
    exp_par = par_odd ? ~^sh_q[7:1] : ^sh_q[7:1];
    tick = (cnt_q == '0);
    st_d = st_q;
    cnt_d = tick ? div - 1'b1 : cnt_q - 1'b1;
    sh_d = sh_q;
    bit_d = bit_q;
    done_d = 1'b0;
    data_d = data_q;
    perr_d = perr_q;
    ferr_d = ferr_q;
    unique case (st_q)
      RX_IDLE: begin
        cnt_d = div >> 1;
        if (enable && prev_q && !rxd) begin
          st_d = RX_START;
        end
      end
      RX_START: if (tick) begin
        st_d = rxd ? RX_IDLE : RX_DATA;
        bit_d = '0;
        perr_d = 1'b0;
      end
      RX_DATA: if (tick) begin
        sh_d = {rxd, sh_q[7:1]};
        bit_d = bit_q + 1'b1;
        if (bit_q == (seven ? 3'h6 : 3'h7)) begin
          st_d = seven ? RX_PAR : RX_STOP; // RULE3
        end
      end
      RX_PAR: if (tick) begin
        perr_d = (rxd != exp_par); // RULE10
        st_d = RX_STOP;
      end
      RX_STOP: if (tick) begin
        done_d = 1'b1; // RULE7
        data_d = seven ? {1'b0, sh_q[7:1]} : sh_q;
        ferr_d = !rxd;
        st_d = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= RX_IDLE;
      cnt_q <= '0;
      sh_q <= '0;
      bit_q <= '0;
      prev_q <= 1'b1;
      done_q <= 1'b0;
      data_q <= '0;
      perr_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      prev_q <= rxd;
      done_q <= done_d;
      data_q <= data_d;
      perr_q <= perr_d;
      ferr_q <= ferr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rx_par_flag_a: assert property ( // RULE10
    (st_q == RX_PAR && cnt_q == '0 && rxd != exp_par) |=> perr_q)
    else $error("parity mismatch not flagged");
  rx_nopar_clean_a: assert property ( // RULE10
    (done_q && !seven && !$past(seven)) |-> !perr_q)
    else $error("parity error on unparitied frame");
endmodule : rspf_rx
`default_nettype wire

// ==== hdl/rspf_top.sv ====
// Remote serial port framing: UART with AXI4-Lite registers
// Behaviour
// RULE1 - Nine baud rates, exactly one selected
// RULE2 - Reset gives 9600, no parity, 1 stop
// RULE3 - Frames: none/8, odd/7 or even/7
// RULE4 - One or two stop bits per character
// RULE5 - Settings restored from non-volatile store, saved on change
// RULE6 - Only one remote port active at once
// RULE7 - Asynchronous character frames, no clock line
// RULE8 - Flow control none, XON/XOFF or RTS/CTS
// RULE9 - Line terminator CR, LF or CR LF
// RULE10 - Parity mismatch flags a parity error
`default_nettype none
module rspf_top
  import rspf_pkg::*;
#(
  parameter int unsigned CLK_HZ = RSPF_CLK_HZ
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [RSPF_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [RSPF_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic txd,
  input wire logic rxd,
  output logic rts_n,
  input wire logic cts_n,
  input wire logic [31:0] nv_rdata,
  input wire logic nv_rvalid,
  output logic [31:0] nv_wdata,
  output logic nv_wr,
  output logic serial_active,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Baud divisors
  logic [RSPF_DIV_W-1:0] div_tab [RSPF_NBAUD];
  for (genvar i = 0; i < RSPF_NBAUD; i++) begin : g_div
    assign div_tab[i] = RSPF_DIV_W'(CLK_HZ / RSPF_BAUD_TAB[i]); // RULE1
  end

  function automatic logic [CFG_W-1:0] merge(logic [CFG_W-1:0] old, logic [31:0] nw);
    logic [CFG_W-1:0] r;
    r = old;
    if (nw[CFG_BAUD_LSB +: 4] <= BAUD_IDX_MAX) r[CFG_BAUD_LSB +: 4] = nw[CFG_BAUD_LSB +: 4];
    if (nw[CFG_FRAME_LSB +: 2] != CODE_BAD) r[CFG_FRAME_LSB +: 2] = nw[CFG_FRAME_LSB +: 2];
    r[CFG_STOP2_BIT] = nw[CFG_STOP2_BIT];
    if (nw[CFG_FLOW_LSB +: 2] != CODE_BAD) r[CFG_FLOW_LSB +: 2] = nw[CFG_FLOW_LSB +: 2];
    if (nw[CFG_EOL_LSB +: 2] != CODE_BAD) r[CFG_EOL_LSB +: 2] = nw[CFG_EOL_LSB +: 2];
    if (nw[CFG_PORT_LSB +: 2] != CODE_BAD) r[CFG_PORT_LSB +: 2] = nw[CFG_PORT_LSB +: 2];
    return r;
  endfunction : merge

  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic nv_ld_q, nv_ld_d, nv_wr_q, nv_wr_d;
  logic [31:0] nv_wdata_q, nv_wdata_d;
  logic [RSPF_DIV_W-1:0] div;
  logic [1:0] frame, flow, eol;
  logic seven, stop2;
  logic wr_go, rd_go, cfg_wr, tx_wr, en_wr, clr_wr, rx_rd;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic rx_done, rx_perr, rx_ferr;
  logic [7:0] rx_data;

  always_comb begin
    div = div_tab[cfg_q[CFG_BAUD_LSB +: 4]];
    frame = cfg_q[CFG_FRAME_LSB +: 2];
    seven = (frame != NO_PARITY_EIGHT_BIT_FRAME); // RULE3
    stop2 = cfg_q[CFG_STOP2_BIT];
    flow = cfg_q[CFG_FLOW_LSB +: 2];
    eol = cfg_q[CFG_EOL_LSB +: 2];
    serial_active = (cfg_q[CFG_PORT_LSB +: 2] == SERIAL_PORT_CHOICE); // RULE6
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and non-volatile copy
  always_comb begin
    cfg_d = cfg_q;
    nv_ld_d = nv_ld_q;
    nv_wr_d = 1'b0;
    nv_wdata_d = nv_wdata_q;
    if (cfg_wr && |wstrb) begin
      cfg_d = merge(cfg_q, wdata);
      nv_ld_d = 1'b1;
      nv_wr_d = 1'b1; // RULE5
      nv_wdata_d = 32'(merge(cfg_q, wdata));
    end else if (!nv_ld_q && nv_rvalid) begin
      cfg_d = merge(CFG_RESET, nv_rdata); // RULE5
      nv_ld_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RESET; // RULE2
      nv_ld_q <= 1'b0;
      nv_wr_q <= 1'b0;
      nv_wdata_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      nv_ld_q <= nv_ld_d;
      nv_wr_q <= nv_wr_d;
      nv_wdata_q <= nv_wdata_d;
    end
  end
  assign nv_wr = nv_wr_q;
  assign nv_wdata = nv_wdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Receive path, flow pause and interrupts
  rspf_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(serial_active), // RULE6
    .rxd(rxd),
    .div(div),
    .seven(seven),
    .par_odd(frame == ODD_PARITY_SEVEN_BIT_FRAME),
    .done_q(rx_done),
    .data_q(rx_data),
    .perr_q(rx_perr),
    .ferr_q(rx_ferr)
  );

  logic [7:0] rx_buf_q, rx_buf_d;
  logic rx_full_q, rx_full_d, rx_pe_q, rx_pe_d, rx_fe_q, rx_fe_d;
  logic paused_q, paused_d, cr_seen_q, cr_seen_d, is_flow, eol_hit;
  logic [IRQ_W-1:0] ist_q, ist_d, ien_q, ien_d, ev;
  logic tx_take, lf_pend_q;

  always_comb begin
    is_flow = rx_done && flow == FLOW_SW && (rx_data == CHR_XON || rx_data == CHR_XOFF);
    unique case (eol) // RULE9
      EOL_CR: eol_hit = rx_data == CHR_CR;
      EOL_LF: eol_hit = rx_data == CHR_LF;
      default: eol_hit = rx_data == CHR_LF && cr_seen_q;
    endcase
    rx_buf_d = rx_buf_q;
    rx_pe_d = rx_pe_q;
    rx_fe_d = rx_fe_q;
    rx_full_d = rx_full_q && !rx_rd;
    cr_seen_d = cr_seen_q;
    ev = '0;
    if (rx_done && !is_flow) begin
      rx_buf_d = rx_data;
      rx_pe_d = rx_perr;
      rx_fe_d = rx_ferr;
      rx_full_d = 1'b1;
      cr_seen_d = rx_data == CHR_CR;
      ev[IRQ_RX] = 1'b1;
      ev[IRQ_PERR] = rx_perr; // RULE10
      ev[IRQ_OVR] = rx_full_q && !rx_rd;
      ev[IRQ_EOL] = eol_hit; // RULE9
    end
    ev[IRQ_TXE] = tx_take && !lf_pend_q;
    paused_d = paused_q;
    if (flow != FLOW_SW) paused_d = 1'b0;
    else if (rx_done && rx_data == CHR_XOFF) paused_d = 1'b1; // RULE8
    else if (rx_done && rx_data == CHR_XON) paused_d = 1'b0; // RULE8
    ien_d = en_wr && |wstrb ? wdata[IRQ_W-1:0] : ien_q;
    ist_d = (ist_q & ~(clr_wr && |wstrb ? wdata[IRQ_W-1:0] : '0)) | ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_q <= '0;
      rx_full_q <= 1'b0;
      rx_pe_q <= 1'b0;
      rx_fe_q <= 1'b0;
      paused_q <= 1'b0;
      cr_seen_q <= 1'b0;
      ist_q <= '0;
      ien_q <= '0;
    end else begin
      rx_buf_q <= rx_buf_d;
      rx_full_q <= rx_full_d;
      rx_pe_q <= rx_pe_d;
      rx_fe_q <= rx_fe_d;
      paused_q <= paused_d;
      cr_seen_q <= cr_seen_d;
      ist_q <= ist_d;
      ien_q <= ien_d;
    end
  end
  assign irq = |(ist_q & ien_q);
  assign rts_n = (flow == FLOW_HW) && rx_full_q; // RULE8

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding register and framer
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} rspf_tx_st_t;
  rspf_tx_st_t tx_st_q, tx_st_d;
  logic [7:0] hold_q, hold_d, tx_sh_q, tx_sh_d;
  logic hold_v_q, hold_v_d, lf_pend_d, tx_go;
  logic [RSPF_DIV_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [2:0] tx_bit_q, tx_bit_d;
  logic txd_q, txd_d, tx_par_q, tx_par_d, stop_left_q, stop_left_d;

  always_comb begin
    tx_go = hold_v_q && serial_active && !(flow == FLOW_SW && paused_q) // RULE8
            && !(flow == FLOW_HW && cts_n);
    tx_take = (tx_st_q == TX_IDLE) && tx_go;
    hold_d = hold_q;
    hold_v_d = hold_v_q;
    lf_pend_d = lf_pend_q;
    if (tx_take) begin
      hold_v_d = lf_pend_q;
      hold_d = CHR_LF;
      lf_pend_d = 1'b0;
    end else if (tx_wr && |wstrb && !hold_v_q && !lf_pend_q) begin
      hold_v_d = 1'b1;
      if (wdata[TX_EOL_BIT]) begin
        hold_d = (eol == EOL_LF) ? CHR_LF : CHR_CR; // RULE9
        lf_pend_d = (eol == EOL_CRLF);
      end else begin
        hold_d = wdata[7:0];
      end
    end
  end

  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q - 1'b1;
    tx_sh_d = tx_sh_q;
    tx_bit_d = tx_bit_q;
    txd_d = txd_q;
    tx_par_d = tx_par_q;
    stop_left_d = stop_left_q;
    if (tx_st_q == TX_IDLE) begin
      txd_d = 1'b1;
      if (tx_take) begin
        tx_st_d = TX_START;
        txd_d = 1'b0; // RULE7
        tx_cnt_d = div - 1'b1;
        tx_sh_d = hold_q;
        tx_par_d = (frame == ODD_PARITY_SEVEN_BIT_FRAME) ? ~^hold_q[6:0] : ^hold_q[6:0];
      end
    end else if (tx_cnt_q == '0) begin
      tx_cnt_d = div - 1'b1;
      unique case (tx_st_q)
        TX_START: begin
          tx_st_d = TX_DATA;
          txd_d = tx_sh_q[0];
          tx_bit_d = '0;
        end
        TX_DATA: begin
          tx_sh_d = tx_sh_q >> 1;
          tx_bit_d = tx_bit_q + 1'b1;
          txd_d = tx_sh_q[1];
          if (tx_bit_q == (seven ? 3'h6 : 3'h7)) begin // RULE3
            tx_st_d = seven ? TX_PAR : TX_STOP;
            txd_d = seven ? tx_par_q : 1'b1;
            stop_left_d = stop2; // RULE4
          end
        end
        TX_PAR: begin
          tx_st_d = TX_STOP;
          txd_d = 1'b1;
        end
        default: begin
          stop_left_d = 1'b0;
          if (!stop_left_q) tx_st_d = TX_IDLE; // RULE4
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_q <= '0;
      hold_v_q <= 1'b0;
      lf_pend_q <= 1'b0;
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_sh_q <= '0;
      tx_bit_q <= '0;
      txd_q <= 1'b1;
      tx_par_q <= 1'b0;
      stop_left_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      hold_v_q <= hold_v_d;
      lf_pend_q <= lf_pend_d;
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_sh_q <= tx_sh_d;
      tx_bit_q <= tx_bit_d;
      txd_q <= txd_d;
      tx_par_q <= tx_par_d;
      stop_left_q <= stop_left_d;
    end
  end
  assign txd = txd_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  always_comb begin
    wr_go = awvalid && wvalid && !bvalid_q;
    awready = wr_go;
    wready = wr_go;
    rd_go = arvalid && !rvalid_q;
    arready = rd_go;
    cfg_wr = wr_go && awaddr == OFF_CTRL;
    tx_wr = wr_go && awaddr == OFF_TXDATA;
    en_wr = wr_go && awaddr == OFF_IRQ_EN;
    clr_wr = wr_go && awaddr == OFF_IRQ_CLR;
    rx_rd = rd_go && araddr == OFF_RXDATA;
    bvalid_d = wr_go || (bvalid_q && !bready);
    bresp_d = bresp_q;
    if (wr_go) begin
      bresp_d = (awaddr == OFF_CTRL || awaddr == OFF_TXDATA || awaddr == OFF_IRQ_EN
                 || awaddr == OFF_IRQ_CLR) ? RESP_OKAY : RESP_DECERR;
    end
    rvalid_d = rd_go || (rvalid_q && !rready);
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rd_go) begin
      rdata_d = '0;
      rresp_d = RESP_OKAY;
      unique case (araddr)
        OFF_CTRL: rdata_d = 32'(cfg_q);
        OFF_STAT: begin
          rdata_d[ST_RX_FULL] = rx_full_q;
          rdata_d[ST_HOLD_FULL] = hold_v_q;
          rdata_d[ST_TX_BUSY] = tx_st_q != TX_IDLE;
          rdata_d[ST_PAUSED] = paused_q;
          rdata_d[ST_CTS] = !cts_n;
          rdata_d[ST_NV_LOADED] = nv_ld_q;
        end
        OFF_RXDATA: rdata_d = {22'h0, rx_fe_q, rx_pe_q, rx_buf_q};
        OFF_IRQ_STAT: rdata_d = 32'(ist_q);
        OFF_IRQ_EN: rdata_d = 32'(ien_q);
        default: rresp_d = RESP_DECERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else begin
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_xoff_seen;
    rx_done && flow == FLOW_SW && rx_data == CHR_XOFF;
  endsequence
  sequence s_tx_held;
    !tx_take [*2];
  endsequence

  baud_legal_a: assert property (cfg_q[CFG_BAUD_LSB +: 4] <= BAUD_IDX_MAX) // RULE1
    else $error("baud index out of range");
  reset_cfg_a: assert property (!nv_ld_q |-> cfg_q == CFG_RESET) // RULE2
    else $error("config left defaults before load");
  frame_legal_a: assert property (frame != CODE_BAD) // RULE3
    else $error("illegal frame code");
  stop_count_a: assert property ( // RULE4
    (tx_st_q != TX_STOP ##1 tx_st_q == TX_STOP) |-> stop_left_q == stop2)
    else $error("stop bit count wrong");
  nv_save_a: assert property ((cfg_wr && |wstrb) |=> nv_wr && nv_wdata == 32'(cfg_q)) // RULE5
    else $error("config change not saved");
  port_idle_a: assert property (!serial_active |=> txd_q && tx_st_q == TX_IDLE || // RULE6
    $past(tx_st_q) != TX_IDLE)
    else $error("transmit started on inactive port");
  start_bit_a: assert property (tx_take |=> !txd_q [*2]) // RULE7
    else $error("start bit too short");
  xoff_pause_a: assert property (s_xoff_seen |=> paused_q ##0 s_tx_held) // RULE8
    else $error("XOFF did not pause transmit");
  cts_hold_a: assert property ( // RULE8
    (flow == FLOW_HW && cts_n && tx_st_q == TX_IDLE) |=> tx_st_q == TX_IDLE)
    else $error("transmit ignored CTS");
  eol_irq_a: assert property ((rx_done && !is_flow && eol_hit) |=> ist_q[IRQ_EOL]) // RULE9
    else $error("terminator not flagged");
  perr_irq_a: assert property ((rx_done && !is_flow && rx_perr) |=> ist_q[IRQ_PERR]) // RULE10
    else $error("parity error not raised");
endmodule : rspf_top
`default_nettype wire

// ==== tb/rspf_host.sv ====
// Host terminal model driving and sampling the serial lines
`default_nettype none
module rspf_host (
  input wire logic aclk,
  input wire logic txd,
  output logic rxd,
  output logic cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rxd = 1'b1;
    cts_n = 1'b0;
  end
  task automatic bit_out(input logic b, input int dv);
    rxd <= b;
    repeat (dv) @(posedge aclk);
  endtask : bit_out
  task automatic hold(input logic v);
    cts_n <= v;
  endtask : hold
  // Frame out: par 0 none, 1 odd, 2 even; bad flips the parity bit
  task automatic send(input logic [7:0] c, input int par, input int st, input int dv,
                      input logic bad);
    @(posedge aclk);
    bit_out(1'b0, dv);
    for (int i = 0; i < (par != 0 ? 7 : 8); i++) bit_out(c[i], dv);
    if (par != 0) bit_out(^c[6:0] ^ (par == 1) ^ bad, dv);
    repeat (st) bit_out(1'b1, dv);
  endtask : send
  // Frame in, sampled mid bit; ok drops on a lost start or a low stop
  task automatic recv(input int par, input int st, input int dv, output logic [7:0] c,
                      output logic p, output logic ok);
    int k;
    c = 8'h00;
    p = 1'b0;
    k = 0;
    while (txd !== 1'b0 && k < 50000) begin
      @(posedge aclk);
      k++;
    end
    repeat (dv / 2) @(posedge aclk);
    ok = (txd === 1'b0) && (k < 50000);
    for (int i = 0; i < (par != 0 ? 7 : 8); i++) begin
      repeat (dv) @(posedge aclk);
      c[i] = txd;
    end
    if (par != 0) begin
      repeat (dv) @(posedge aclk);
      p = txd;
    end
    repeat (st) begin
      repeat (dv) @(posedge aclk);
      ok = ok && (txd === 1'b1);
    end
  endtask : recv
endmodule : rspf_host
`default_nettype wire

// ==== tb/tb_rspf_top.sv ====
// Testbench of the remote serial port framing block
`default_nettype none
module tb_rspf_top
  import rspf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HZ = 1_200_000;
  localparam int DV = HZ / RSPF_BAUD_TAB[7];
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, nv_rvalid, nv_wr;
  logic awready, wready, bvalid, arready, rvalid, txd, rxd, rts_n, cts_n, serial_active, irq;
  logic [7:0] awaddr, araddr, d;
  logic [31:0] wdata, rdata, nv_rdata, nv_wdata, nv_seen, v, w;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic p, ok;
  int n_fail, checked;
  rspf_top #(.CLK_HZ(HZ)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .txd, .rxd, .rts_n, .cts_n, .nv_rdata, .nv_rvalid, .nv_wdata, .nv_wr,
    .serial_active, .irq);
  rspf_host host (.aclk, .txd, .rxd, .cts_n);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (nv_wr === 1'b1) nv_seen <= nv_wdata;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) begin
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
      n_fail++;
    end
  endtask : chk
  task automatic hang(input int k);
    if (k >= 200) begin
      $display("unexpected at %0t: bus timeout", $time);
      n_fail++;
      tally_and_finish();
    end
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    int k;
    @(posedge aclk);
    k = 0;
    awaddr <= a;
    wdata <= dat;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
    end while (awready !== 1'b1 && k < 200);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
    resp = bresp;
    bready <= 1'b0;
    hang(k);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dat);
    int k;
    @(posedge aclk);
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
    end while (arready !== 1'b1 && k < 200);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && k < 200) begin
      @(posedge aclk);
      k++;
    end
    dat = rdata;
    resp = rresp;
    rready <= 1'b0;
    hang(k);
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    rd(a, v);
    chk(v, e, m);
  endtask : rchk
  function automatic logic [31:0] cfg(input int b, input int f, input int s, input int e,
                                      input int pt);
    return (32'(b) << CFG_BAUD_LSB) | (32'(f) << CFG_FRAME_LSB) | (32'(s) << CFG_STOP2_BIT)
         | (32'(e) << CFG_EOL_LSB) | (32'(pt) << CFG_PORT_LSB);
  endfunction : cfg
  task automatic rx_exp(input int f, input int s, input logic [7:0] c);
    host.recv(f, s, DV, d, p, ok);
    chk({ok, d}, {1'b1, f != 0 ? {1'b0, c[6:0]} : c}, "frame data");
    if (f != 0) chk(p, ^c[6:0] ^ (f == 1), "parity bit");
  endtask : rx_exp
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, nv_rvalid} = 7'h00;
    {awaddr, araddr, wdata, nv_rdata} = '0;
    wstrb = 4'hf;
    n_fail = 0;
    checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFF_CTRL, cfg(3, NO_PARITY_EIGHT_BIT_FRAME, 0, EOL_CRLF, 0), "reset cfg");
    chk(serial_active, 1'b1, "serial on");
    chk(txd, 1'b1, "idle line");
    $display("test reset finished");
    w = cfg(5, EVEN_PARITY_SEVEN_BIT_FRAME, 1, EOL_LF, SERIAL_PORT_CHOICE);
    nv_rdata <= w;
    nv_rvalid <= 1'b1;
    @(posedge aclk);
    nv_rvalid <= 1'b0;
    nv_rdata <= 32'h0;
    @(posedge aclk);
    nv_rvalid <= 1'b1;
    @(posedge aclk);
    nv_rvalid <= 1'b0;
    rchk(OFF_CTRL, w, "nv restore");
    rd(OFF_STAT, v);
    chk(v[ST_NV_LOADED], 1'b1, "nv flag");
    $display("test restore finished");
    for (int i = 0; i < RSPF_NBAUD; i++) begin
      w = cfg(i, NO_PARITY_EIGHT_BIT_FRAME, 0, EOL_CR, SERIAL_PORT_CHOICE);
      wr(OFF_CTRL, w);
      fork
        host.recv(0, 1, HZ / RSPF_BAUD_TAB[i], d, p, ok);
        wr(OFF_TXDATA, 32'h5a);
      join
      chk({ok, d}, {1'b1, 8'h5a}, "tx at rate");
      chk(nv_seen, w, "nv save");
    end
    $display("test rates finished");
    for (int f = 0; f < 3; f++) begin
      for (int s = 0; s < 2; s++) begin
        wr(OFF_CTRL, cfg(7, f, s, EOL_CR, SERIAL_PORT_CHOICE));
        fork
          begin
            rx_exp(f, s + 1, 8'hc3);
            rx_exp(f, s + 1, 8'h3c);
          end
          begin
            wr(OFF_TXDATA, 32'hc3);
            wr(OFF_TXDATA, 32'h3c);
          end
        join
        host.send(8'ha5, f, s + 1, DV, 1'b0);
        rchk(OFF_RXDATA, f != 0 ? 32'h25 : 32'ha5, "rx data");
      end
    end
    $display("test frames finished");
    wr(OFF_CTRL, cfg(7, ODD_PARITY_SEVEN_BIT_FRAME, 0, EOL_CR, SERIAL_PORT_CHOICE));
    wr(OFF_IRQ_EN, 32'h1 << IRQ_PERR);
    host.send(8'h41, 1, 1, DV, 1'b1);
    @(posedge aclk);
    chk(irq, 1'b1, "irq on parity");
    rchk(OFF_RXDATA, (32'h1 << RX_PERR_BIT) | 32'h41, "parity flag");
    wr(OFF_IRQ_CLR, 32'h1 << IRQ_PERR);
    @(posedge aclk);
    chk(irq, 1'b0, "irq cleared");
    $display("test parity finished");
    w = cfg(7, ODD_PARITY_SEVEN_BIT_FRAME, 0, EOL_CR, PORT_LAN);
    wr(OFF_CTRL, w);
    wr(OFF_CTRL, w | (32'(CODE_BAD) << CFG_PORT_LSB));
    rchk(OFF_CTRL, w, "port code");
    chk(serial_active, 1'b0, "port off");
    chk(nv_seen, w, "port saved");
    rd(8'h40, v);
    chk(resp, RESP_DECERR, "unmapped read");
    wr(8'h40, 32'h0);
    chk(resp, RESP_DECERR, "unmapped write");
    $display("test ports finished");
    w = cfg(7, 0, 0, EOL_CRLF, 0) | (32'(FLOW_HW) << CFG_FLOW_LSB);
    wr(OFF_CTRL, w);
    wr(OFF_IRQ_EN, 32'h1 << IRQ_EOL);
    host.send(CHR_CR, 0, 1, DV, 1'b0);
    chk({irq, rts_n}, 2'b01, "cr held");
    rchk(OFF_RXDATA, 32'(CHR_CR), "cr in");
    chk(rts_n, 1'b0, "rts free");
    host.send(CHR_LF, 0, 1, DV, 1'b0);
    @(posedge aclk);
    chk(irq, 1'b1, "crlf seen");
    rchk(OFF_RXDATA, 32'(CHR_LF), "lf in");
    host.hold(1'b1);
    wr(OFF_TXDATA, 32'h1 << TX_EOL_BIT);
    repeat (30) @(posedge aclk);
    rchk(OFF_STAT, 32'h22, "cts held");
    host.hold(1'b0);
    rx_exp(0, 1, CHR_CR);
    rx_exp(0, 1, CHR_LF);
    wr(OFF_CTRL, w ^ (32'h3 << CFG_FLOW_LSB));
    host.send(CHR_XOFF, 0, 1, DV, 1'b0);
    wr(OFF_TXDATA, 32'h5a);
    repeat (30) @(posedge aclk);
    rchk(OFF_STAT, 32'h3a, "paused");
    fork
      host.send(CHR_XON, 0, 1, DV, 1'b0);
      rx_exp(0, 1, 8'h5a);
    join
    $display("test flow finished");
    tally_and_finish();
  end
endmodule : tb_rspf_top
`default_nettype wire
